// File: ufa_consts.vh
// constants for the serial port with framing check and address matching
// Notes on behaviour
// - modes 1, 2, 3 are full-duplex asynchronous; mode 0 is the synchronous shifter.
// - transmitter and receiver run independently, each from its own rate divisor except in mode 2, where both use the fixed divisor.
// - stop-bit checking works in modes 1-3 only while frame_check_enable is one.
// - a stop bit sampled low sets framing_error_flag when checking is on.
// - framing_error_flag stays set until software writes it zero or reset; good frames keep it.
// - with checking on, receive_done_flag rises at stop bit, not last data bit.
// - given address compares only bits whose slave_address_mask bit is one.
// - broadcast is address OR mask; its zero bits match either received value.
// - reset clears address and mask, so every address is accepted.
`ifndef UFA_CONSTS_VH
`define UFA_CONSTS_VH

// register indices, byte address is four times the index
`define UFA_IDX_CTRL   8'h10
`define UFA_IDX_DATA   8'h11
`define UFA_IDX_POWER  8'h12
`define UFA_IDX_TXDIV  8'h13
`define UFA_IDX_RXDIV  8'h14
`define UFA_IDX_ISTAT  8'h15
`define UFA_IDX_IMASK  8'h16
`define UFA_IDX_SLVADR 8'hA9
`define UFA_IDX_SLVMSK 8'hB9

// serial_control_reg field positions
`define UFA_C_RXDONE   0
`define UFA_C_TI       1
`define UFA_C_RB8      2
`define UFA_C_TB8      3
`define UFA_C_REN      4
`define UFA_C_MPE      5
`define UFA_C_MODE_LO  6
`define UFA_C_MODE_HI  7
`define UFA_C_FERR     8

// power_control_reg field position
`define UFA_P_FCE      6

// interrupt status and mask bits
`define UFA_EV_TX      0
`define UFA_EV_RX      1
`define UFA_EV_FERR    2
`define UFA_EV_W       3

// operating modes
`define UFA_MODE_SYNC  2'h0
`define UFA_MODE_A8    2'h1
`define UFA_MODE_A9F   2'h2
`define UFA_MODE_A9V   2'h3

// reset values
`define UFA_RST8       8'h00
`define UFA_RST_EV     3'h0
`define UFA_RST_DIV    16'h0035
`define UFA_FIXED_DIV  16'h0001

// sixteen rate ticks per bit, sampled in the middle
`define UFA_OS_MID     4'h7
`define UFA_OS_LAST    4'hF

// frame lengths in bits
`define UFA_LEN_SYNC   4'h8
`define UFA_LEN_A8     4'hA
`define UFA_LEN_A9     4'hB
`define UFA_NDATA8     4'h8
`define UFA_NDATA9     4'h9

`endif

// File: ufa_rate_gen.v
// rate divider giving a one-cycle tick every divisor plus one clocks
`timescale 1ns/10ps
`default_nettype none
module ufa_rate_gen #(
	parameter W = 16
) (
	input  wire         ref_clk_i,
	input  wire         sys_rst_i,
	input  wire         run_i,
	input  wire [W-1:0] divisor_i,
	output reg          tick_o
);
	reg [W-1:0] cnt;

	// count down while running, restart aligned when stopped
	always @(posedge ref_clk_i) begin
		if (sys_rst_i || !run_i) begin
			cnt    <= {W{1'b0}};
			tick_o <= 1'b0;
		end else if (cnt == {W{1'b0}}) begin
			cnt    <= divisor_i;
			tick_o <= 1'b1;
		end else begin
			cnt    <= cnt - {{(W-1){1'b0}}, 1'b1};
			tick_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// File: ufa_remote_node.sv
// remote serial node that sends frames into the port
`timescale 1ns/10ps
`default_nettype none
module ufa_remote_node (
	input  wire logic ref_clk_i,
	output var  logic line_o
);
// line rests high between frames
initial line_o = 1'h1;
// start, data lsb first, optional ninth bit, then stop level
task automatic send(input logic [8:0] d, input logic nine,
	input logic stop, input int bt);
	logic [10:0] f;
	int n;
	f = nine ? {stop, d, 1'h0} : {1'h1, stop, d[7:0], 1'h0};
	n = nine ? 11 : 10;
	for (int i = 0; i < n; i++) begin
		@(posedge ref_clk_i);
		line_o <= f[i];
		repeat (bt - 1) @(posedge ref_clk_i);
	end
	@(posedge ref_clk_i);
	line_o <= 1'h1;
	repeat (bt) @(posedge ref_clk_i);
endtask
endmodule
`default_nettype wire

// File: ufa_serial_port.v
// serial port with framing check, address matching and avalon-mm registers
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "ufa_consts.vh"
module ufa_serial_port #(
	parameter DIV_W     = 16,
	parameter FIXED_DIV = `UFA_FIXED_DIV
) (
	input  wire        ref_clk_i,
	input  wire        sys_rst_i,
	input  wire [7:0]  avs_address_i,
	input  wire        avs_read_i,
	input  wire        avs_write_i,
	input  wire [31:0] avs_writedata_i,
	output reg  [31:0] avs_readdata_o,
	output reg         avs_waitrequest_o,
	input  wire        serial_in_i,
	output reg         serial_out_o,
	output reg         shift_clk_o,
	output reg         irq_o
);
	localparam R_IDLE  = 4'h1;
	localparam R_START = 4'h2;
	localparam R_DATA  = 4'h4;
	localparam R_STOP  = 4'h8;
	localparam T_IDLE  = 2'h1;
	localparam T_SEND  = 2'h2;

	// software visible state
	reg [1:0]       mode;
	reg             mpe;
	reg             ren;
	reg             tb8;
	reg             rb8;
	reg             ti;
	reg             rx_flag;
	reg             err_flag;
	reg             fce;
	reg [7:0]       rx_buf;
	reg [7:0]       slv_adr;
	reg [7:0]       slv_msk;
	reg [DIV_W-1:0] tx_div;
	reg [DIV_W-1:0] rx_div;
	reg [2:0]       istat;
	reg [2:0]       imask;

	// engine state
	reg [3:0]       rx_state;
	reg [3:0]       rx_os;
	reg [3:0]       rx_cnt;
	reg [8:0]       rx_shift;
	reg [1:0]       tx_state;
	reg [3:0]       tx_os;
	reg [3:0]       tx_cnt;
	reg [3:0]       tx_len;
	reg [10:0]      tx_shift;
	reg [31:0]      next_readdata;

	wire            rx_tick;
	wire            tx_tick;

	// bus handshake: a request is taken at the edge where waitrequest is low
	wire wr_go = avs_write_i && !avs_waitrequest_o;
	wire wr_ctrl  = wr_go && (avs_address_i == `UFA_IDX_CTRL);
	wire wr_data  = wr_go && (avs_address_i == `UFA_IDX_DATA);
	wire wr_power = wr_go && (avs_address_i == `UFA_IDX_POWER);
	wire wr_txdiv = wr_go && (avs_address_i == `UFA_IDX_TXDIV);
	wire wr_rxdiv = wr_go && (avs_address_i == `UFA_IDX_RXDIV);
	wire wr_istat = wr_go && (avs_address_i == `UFA_IDX_ISTAT);
	wire wr_imask = wr_go && (avs_address_i == `UFA_IDX_IMASK);
	wire wr_slvadr = wr_go && (avs_address_i == `UFA_IDX_SLVADR);
	wire wr_slvmsk = wr_go && (avs_address_i == `UFA_IDX_SLVMSK);

	// nine-bit frames in modes 2 and 3, fixed rate in mode 2
	wire nine = mode[1];
	wire [DIV_W-1:0] tx_rate = (mode == `UFA_MODE_A9F) ?
		FIXED_DIV[DIV_W-1:0] : tx_div;
	wire [DIV_W-1:0] rx_rate = (mode == `UFA_MODE_A9F) ?
		FIXED_DIV[DIV_W-1:0] : rx_div;

	// separate dividers so both directions keep their own rate
	ufa_rate_gen #(.W(DIV_W)) u_tx_rate (
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.run_i     (tx_state == T_SEND),
		.divisor_i (tx_rate),
		.tick_o    (tx_tick)
	);
	ufa_rate_gen #(.W(DIV_W)) u_rx_rate (
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.run_i     (rx_state != R_IDLE),
		.divisor_i (rx_rate),
		.tick_o    (rx_tick)
	);

	// receive sampling points and frame capture
	wire rx_sample = rx_tick && (rx_os == `UFA_OS_MID);
	wire [3:0] n_data = nine ? `UFA_NDATA9 : `UFA_NDATA8;
	wire last_data = (rx_cnt == n_data - 4'h1);
	wire early_pt = rx_sample && (rx_state == R_DATA) && last_data && !fce;
	wire stop_pt  = rx_sample && (rx_state == R_STOP);
	wire deliver  = early_pt || (stop_pt && fce);
	wire [8:0] cap = early_pt ? {serial_in_i, rx_shift[8:1]} : rx_shift;
	wire [7:0] cap_byte = nine ? cap[7:0] : cap[8:1];
	wire cap_ninth = nine & cap[8];

	// address matching on given and broadcast address
	wire given_hit = (((cap_byte ^ slv_adr) & slv_msk) == `UFA_RST8);
	wire bcast_hit = ((~cap_byte & (slv_adr | slv_msk)) == `UFA_RST8);
	wire accept = !(mpe && nine) ||
		(cap_ninth && (given_hit || bcast_hit));
	wire rx_done_ev = deliver && accept;
	wire err_ev = stop_pt && fce && !serial_in_i;
	wire tx_done_ev = (tx_state == T_SEND) && tx_tick &&
		(tx_os == `UFA_OS_LAST) && (tx_cnt == tx_len - 4'h1);

	// receiver: start, data, stop, one-hot
	always @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			rx_state <= R_IDLE;
			rx_os    <= 4'h0;
			rx_cnt   <= 4'h0;
			rx_shift <= 9'h000;
		end else begin
			if (rx_state == R_IDLE)
				rx_os <= 4'h0;
			else if (rx_tick)
				rx_os <= rx_os + 4'h1;
			case (rx_state)
			R_IDLE: begin
				if (ren && mode != `UFA_MODE_SYNC && !serial_in_i)
					rx_state <= R_START;
			end
			R_START: begin
				if (rx_sample) begin
					rx_cnt   <= 4'h0;
					rx_state <= serial_in_i ? R_IDLE : R_DATA;
				end
			end
			R_DATA: begin
				if (rx_sample) begin
					rx_shift <= {serial_in_i, rx_shift[8:1]};
					rx_cnt   <= rx_cnt + 4'h1;
					if (last_data)
						rx_state <= R_STOP;
				end
			end
			R_STOP: begin
				if (rx_sample)
					rx_state <= R_IDLE;
			end
			default: rx_state <= R_IDLE;
			endcase
		end
	end

	// transmitter: frame shifter, runs on its own divider
	always @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			tx_state     <= T_IDLE;
			tx_os        <= 4'h0;
			tx_cnt       <= 4'h0;
			tx_len       <= `UFA_LEN_A8;
			tx_shift     <= 11'h7FF;
			serial_out_o <= 1'b1;
			shift_clk_o  <= 1'b1;
		end else begin
			case (tx_state)
			T_IDLE: begin
				shift_clk_o <= 1'b1;
				if (wr_data) begin
					tx_state <= T_SEND;
					tx_os    <= 4'h0;
					tx_cnt   <= 4'h0;
					if (mode == `UFA_MODE_SYNC) begin
						tx_len       <= `UFA_LEN_SYNC;
						tx_shift     <= {3'h7, avs_writedata_i[7:0]};
						serial_out_o <= avs_writedata_i[0];
					end else if (nine) begin
						tx_len       <= `UFA_LEN_A9;
						tx_shift     <= {1'b1, tb8,
							avs_writedata_i[7:0], 1'b0};
						serial_out_o <= 1'b0;
					end else begin
						tx_len       <= `UFA_LEN_A8;
						tx_shift     <= {2'h3, avs_writedata_i[7:0], 1'b0};
						serial_out_o <= 1'b0;
					end
				end
			end
			T_SEND: begin
				// in mode 0 the shift clock is low for the first half bit
				shift_clk_o <= (mode == `UFA_MODE_SYNC) ? tx_os[3] : 1'b1;
				if (tx_tick) begin
					tx_os <= tx_os + 4'h1;
					if (tx_os == `UFA_OS_LAST) begin
						tx_cnt       <= tx_cnt + 4'h1;
						tx_shift     <= {1'b1, tx_shift[10:1]};
						serial_out_o <= tx_shift[1];
						if (tx_done_ev) begin
							tx_state     <= T_IDLE;
							serial_out_o <= 1'b1;
						end
					end
				end
			end
			default: tx_state <= T_IDLE;
			endcase
		end
	end

	// control, address and rate registers
	always @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			mode   <= `UFA_MODE_SYNC;
			mpe    <= 1'b0;
			ren    <= 1'b0;
			tb8    <= 1'b0;
			fce    <= 1'b0;
			slv_adr <= `UFA_RST8;
			slv_msk <= `UFA_RST8;
			tx_div <= `UFA_RST_DIV;
			rx_div <= `UFA_RST_DIV;
			imask  <= `UFA_RST_EV;
		end else begin
			if (wr_ctrl) begin
				mode <= avs_writedata_i[`UFA_C_MODE_HI:`UFA_C_MODE_LO];
				mpe  <= avs_writedata_i[`UFA_C_MPE];
				ren  <= avs_writedata_i[`UFA_C_REN];
				tb8  <= avs_writedata_i[`UFA_C_TB8];
			end
			if (wr_power)
				fce <= avs_writedata_i[`UFA_P_FCE];
			if (wr_slvadr)
				slv_adr <= avs_writedata_i[7:0];
			if (wr_slvmsk)
				slv_msk <= avs_writedata_i[7:0];
			if (wr_txdiv)
				tx_div <= avs_writedata_i[DIV_W-1:0];
			if (wr_rxdiv)
				rx_div <= avs_writedata_i[DIV_W-1:0];
			if (wr_imask)
				imask <= avs_writedata_i[`UFA_EV_W-1:0];
		end
	end

	// flags: hardware set wins over a software clear in the same cycle
	always @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			rx_flag  <= 1'b0;
			ti       <= 1'b0;
			err_flag <= 1'b0;
			rb8    <= 1'b0;
			rx_buf <= `UFA_RST8;
			istat  <= `UFA_RST_EV;
		end else begin
			if (rx_done_ev) begin
				rx_flag <= 1'b1;
				rx_buf <= cap_byte;
				rb8    <= cap_ninth;
			end else if (wr_ctrl) begin
				rx_flag <= avs_writedata_i[`UFA_C_RXDONE];
			end
			if (tx_done_ev)
				ti <= 1'b1;
			else if (wr_ctrl)
				ti <= avs_writedata_i[`UFA_C_TI];
			// a write of zero clears, later good frames never do
			if (err_ev)
				err_flag <= 1'b1;
			else if (wr_ctrl)
				err_flag <= err_flag & avs_writedata_i[`UFA_C_FERR];
			istat[`UFA_EV_TX] <= tx_done_ev ||
				(istat[`UFA_EV_TX] &
				!(wr_istat && avs_writedata_i[`UFA_EV_TX]));
			istat[`UFA_EV_RX] <= rx_done_ev ||
				(istat[`UFA_EV_RX] &
				!(wr_istat && avs_writedata_i[`UFA_EV_RX]));
			istat[`UFA_EV_FERR] <= err_ev ||
				(istat[`UFA_EV_FERR] &
				!(wr_istat && avs_writedata_i[`UFA_EV_FERR]));
		end
	end

	// level interrupt from unmasked sticky status
	always @(posedge ref_clk_i) begin
		if (sys_rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(istat & imask);
	end

	// read data decode, unmapped indices read as zero
	always @* begin
		next_readdata = 32'h0000_0000;
		if (avs_address_i == `UFA_IDX_CTRL)
			next_readdata[`UFA_C_FERR:0] = {err_flag, mode, mpe,
				ren, tb8, rb8, ti, rx_flag};
		else if (avs_address_i == `UFA_IDX_DATA)
			next_readdata[7:0] = rx_buf;
		else if (avs_address_i == `UFA_IDX_POWER)
			next_readdata[`UFA_P_FCE] = fce;
		else if (avs_address_i == `UFA_IDX_TXDIV)
			next_readdata[DIV_W-1:0] = tx_div;
		else if (avs_address_i == `UFA_IDX_RXDIV)
			next_readdata[DIV_W-1:0] = rx_div;
		else if (avs_address_i == `UFA_IDX_ISTAT)
			next_readdata[`UFA_EV_W-1:0] = istat;
		else if (avs_address_i == `UFA_IDX_IMASK)
			next_readdata[`UFA_EV_W-1:0] = imask;
		else if (avs_address_i == `UFA_IDX_SLVADR)
			next_readdata[7:0] = slv_adr;
		else if (avs_address_i == `UFA_IDX_SLVMSK)
			next_readdata[7:0] = slv_msk;
	end

	// one wait cycle per access: data latched at the same edge that waitrequest drops
	always @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o    <= 32'h0000_0000;
		end else if (!avs_waitrequest_o) begin
			avs_waitrequest_o <= 1'b1;
		end else if (avs_read_i || avs_write_i) begin
			avs_waitrequest_o <= 1'b0;
			if (avs_read_i)
				avs_readdata_o <= next_readdata;
		end
	end
endmodule
`default_nettype wire

// File: ufa_serial_port_properties.sv
// checker for bus timing, address registers and framing flag
`timescale 1ns/10ps
`default_nettype none
`include "ufa_consts.vh"
module ufa_serial_port_chk (
	input wire logic        ref_clk_i,
	input wire logic        sys_rst_i,
	input wire logic [7:0]  avs_address_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic        avs_waitrequest_o,
	input wire logic        serial_in_i,
	input wire logic        serial_out_o,
	input wire logic        shift_clk_o,
	input wire logic        irq_o
);
default clocking @(posedge ref_clk_i); endclocking
default disable iff (sys_rst_i);
logic [7:0] sa;
logic [7:0] sm;
logic [1:0] md;
logic       fce;
logic       fes;
wire        wa = avs_write_i && !avs_waitrequest_o;
wire        ra = avs_read_i && !avs_waitrequest_o;
wire [7:0]  ad = avs_address_i;
// shadows of what the bus has written and what reads have shown
always_ff @(posedge ref_clk_i) begin
	if (sys_rst_i) begin
		sa  <= 8'h00;
		sm  <= 8'h00;
		md  <= 2'h0;
		fce <= 1'h0;
		fes <= 1'h0;
	end else begin
		if (wa && ad == `UFA_IDX_SLVADR) sa <= avs_writedata_i[7:0];
		if (wa && ad == `UFA_IDX_SLVMSK) sm <= avs_writedata_i[7:0];
		if (wa && ad == `UFA_IDX_CTRL) md <= avs_writedata_i[7:6];
		if (wa && ad == `UFA_IDX_POWER && avs_writedata_i[6]) fce <= 1'h1;
		if (ra && ad == `UFA_IDX_CTRL && avs_readdata_o[8]) fes <= 1'h1;
		else if (wa && ad == `UFA_IDX_CTRL && !avs_writedata_i[8]) fes <= 1'h0;
	end
end
// a pending request, then a one-cycle acknowledge
sequence bus_req;
	(avs_read_i || avs_write_i) && avs_waitrequest_o;
endsequence
sequence acked;
	!avs_waitrequest_o ##1 avs_waitrequest_o;
endsequence
ack_timing_a: assert property (bus_req |=> acked)
	else $error("acknowledge not one cycle after request");
reset_idle_a: assert property ($fell(sys_rst_i) |->
	serial_out_o && shift_clk_o && !irq_o && avs_waitrequest_o)
	else $error("outputs not idle after reset");
addr_reg_a: assert property (ra && ad == `UFA_IDX_SLVADR |->
	avs_readdata_o == {24'h00_0000, sa}) else $error("address reg wrong");
mask_reg_a: assert property (ra && ad == `UFA_IDX_SLVMSK |->
	avs_readdata_o == {24'h00_0000, sm}) else $error("mask reg wrong");
err_sticky_a: assert property (ra && ad == `UFA_IDX_CTRL && fes |->
	avs_readdata_o[8]) else $error("framing flag lost");
err_gated_a: assert property (ra && ad == `UFA_IDX_CTRL && !fce |->
	!avs_readdata_o[8]) else $error("framing flag while check off");
sync_clock_a: assert property (md != 2'h0 |=> shift_clk_o)
	else $error("shift clock moved in an async mode");
unmapped_read_a: assert property (ra && ad > `UFA_IDX_IMASK &&
	ad < `UFA_IDX_SLVADR |-> avs_readdata_o == 32'h0000_0000)
	else $error("unmapped read not zero");
endmodule
bind ufa_serial_port ufa_serial_port_chk i_chk (
	.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
	.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
	.avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .serial_in_i(serial_in_i),
	.serial_out_o(serial_out_o), .shift_clk_o(shift_clk_o),
	.irq_o(irq_o));
`default_nettype wire

// File: ufa_serial_port_test.sv
// testbench for the serial port with framing check and address match
`timescale 1ns/10ps
`default_nettype none
`include "ufa_consts.vh"
module ufa_serial_port_test;
localparam int FIX = 1;
logic        ref_clk = 1'h0;
logic        sys_rst = 1'h1;
logic [7:0]  adr = 8'h00;
logic        rd = 1'h0;
logic        wr = 1'h0;
logic [31:0] wdat = 32'h0000_0000;
logic [31:0] rdat;
logic        wreq;
logic        sin;
logic        sout;
logic        irq;
logic [31:0] q;
int          miscompares = 0;
int          num_checks = 0;
logic [8:0]  frm [7] = '{9'h1F0, 9'h1F5, 9'h1F2, 9'h1FF, 9'h1FB, 9'h170,
	9'h0F0};
logic        hit [7] = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0};
// clock
always #5 ref_clk = ~ref_clk;
ufa_serial_port #(.FIXED_DIV(FIX)) i_ufa_serial_port (
	.ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .avs_address_i(adr),
	.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
	.avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .serial_in_i(sin),
	.serial_out_o(sout), .shift_clk_o(), .irq_o(irq));
ufa_remote_node i_ufa_remote_node (.ref_clk_i(ref_clk), .line_o(sin));
// verdict and end of run
task conclude;
	$display("checks %0d mismatches %0d", num_checks, miscompares);
	if (miscompares == 0 && num_checks > 0)
		$display("Simulation passed");
	else
		$display("Simulation failed");
	$finish;
endtask
// compares one value
task check(input string nm, input logic [31:0] s, input logic [31:0] e);
	num_checks++;
	if (s !== e) begin
		miscompares++;
		$display("mismatch %s expected %h seen %h", nm, e, s);
	end
endtask
// one bus access held until waitrequest is seen low
task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
	int k;
	@(posedge ref_clk);
	adr <= a;
	wdat <= d;
	wr <= w;
	rd <= !w;
	k = 0;
	do begin
		@(posedge ref_clk);
		k++;
	end while (wreq !== 1'h0 && k < 64);
	q = rdat;
	rd <= 1'h0;
	wr <= 1'h0;
	if (k >= 64) begin
		miscompares++;
		conclude();
	end
endtask
task put(input logic [7:0] a, input logic [31:0] d);
	acc(1'h1, a, d);
endtask
task rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
	acc(1'h0, a, 32'h0000_0000);
	check(nm, q, e);
endtask
// samples one transmitted frame in the middle of each bit
task txchk(input logic [7:0] b, input int bt);
	logic [9:0] f;
	for (int i = 0; i < 10; i++) begin
		repeat ((i == 0) ? bt / 2 : bt) @(posedge ref_clk);
		f[i] = sout;
	end
	check("tx frame", {22'h0, f}, {22'h0, 1'h1, b, 1'h0});
endtask
// main sequence
initial begin
	repeat (16) @(posedge ref_clk);
	sys_rst <= 1'h0;
	rdchk(`UFA_IDX_SLVADR, 32'h0000_0000, "addr reset");
	rdchk(`UFA_IDX_SLVMSK, 32'h0000_0000, "mask reset");
	rdchk(8'h20, 32'h0000_0000, "unmapped");
	put(`UFA_IDX_RXDIV, 32'h0000_0000);
	put(`UFA_IDX_IMASK, 32'h0000_0006);
	put(`UFA_IDX_CTRL, 32'h0000_0050);
	put(`UFA_IDX_TXDIV, 32'h0000_0001);
	put(`UFA_IDX_DATA, 32'h0000_00C3);
	// a frame goes out at half the rate while one comes in
	fork
		i_ufa_remote_node.send(9'h0A5, 1'h0, 1'h1, 16);
		txchk(8'hC3, 32);
	join
	rdchk(`UFA_IDX_DATA, 32'h0000_00A5, "rx byte");
	i_ufa_remote_node.send(9'h03C, 1'h0, 1'h0, 16);
	rdchk(`UFA_IDX_CTRL, 32'h0000_0053, "err off");
	check("irq rx", irq, 1'h1);
	put(`UFA_IDX_ISTAT, 32'h0000_0007);
	put(`UFA_IDX_POWER, 32'h0000_0040);
	put(`UFA_IDX_CTRL, 32'h0000_0050);
	check("irq clear", irq, 1'h0);
	fork
		i_ufa_remote_node.send(9'h011, 1'h0, 1'h1, 16);
		begin
			repeat (144) @(posedge ref_clk);
			check("done early", irq, 1'h0);
			repeat (24) @(posedge ref_clk);
			check("done late", irq, 1'h1);
		end
	join
	put(`UFA_IDX_CTRL, 32'h0000_0050);
	put(`UFA_IDX_ISTAT, 32'h0000_0007);
	put(`UFA_IDX_IMASK, 32'h0000_0000);
	i_ufa_remote_node.send(9'h05A, 1'h0, 1'h0, 16);
	check("irq masked", irq, 1'h0);
	rdchk(`UFA_IDX_CTRL, 32'h0000_0151, "err set");
	rdchk(`UFA_IDX_ISTAT, 32'h0000_0006, "events");
	put(`UFA_IDX_IMASK, 32'h0000_0004);
	rdchk(`UFA_IDX_DATA, 32'h0000_005A, "err data");
	check("irq err", irq, 1'h1);
	i_ufa_remote_node.send(9'h011, 1'h0, 1'h1, 16);
	rdchk(`UFA_IDX_CTRL, 32'h0000_0151, "err kept");
	put(`UFA_IDX_CTRL, 32'h0000_0050);
	rdchk(`UFA_IDX_CTRL, 32'h0000_0050, "err clear");
	put(`UFA_IDX_CTRL, 32'h0000_00F0);
	i_ufa_remote_node.send(9'h13C, 1'h1, 1'h1, 16);
	rdchk(`UFA_IDX_CTRL, 32'h0000_00F5, "any addr");
	put(`UFA_IDX_SLVADR, 32'h0000_00F1);
	put(`UFA_IDX_SLVMSK, 32'h0000_00FA);
	for (int i = 0; i < 7; i++) begin
		put(`UFA_IDX_CTRL, 32'h0000_00F0);
		i_ufa_remote_node.send(frm[i], 1'h1, 1'h1, 16);
		acc(1'h0, `UFA_IDX_CTRL, 32'h0000_0000);
		check("match", {31'h0, q[0]}, {31'h0, hit[i]});
	end
	put(`UFA_IDX_CTRL, 32'h0000_00B0);
	i_ufa_remote_node.send(9'h1FF, 1'h1, 1'h1, 16 * (FIX + 1));
	acc(1'h0, `UFA_IDX_CTRL, 32'h0000_0000);
	check("mode two", {31'h0, q[0]}, 32'h0000_0001);
	conclude();
end
endmodule
`default_nettype wire
